// ### hdl/sar_pkg.sv
// sar_pkg: shared constants, register map and types for the converter
// sequencer. Assumes a 100 MHz mclk and an AXI4-Lite master with 32-bit data.
package sar_pkg;
   localparam int AW = 12;
   localparam int DW = 32;
   localparam int PW = 24;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL = 8'h00;
   localparam logic [7:0] IDX_STATUS = 8'h01;
   localparam logic [7:0] IDX_CMD_BASE = 8'h02;
   localparam logic [7:0] IDX_RES_BASE = 8'h03;
   localparam logic [7:0] IDX_RESULT = 8'h04;
   localparam logic [7:0] IDX_INDEX = 8'h05;
   localparam logic [7:0] IDX_OFF0 = 8'h24;
   localparam logic [7:0] IDX_OFF1 = 8'h25;
   // control register fields
   localparam int C_EN = 0;
   localparam int C_SMOD = 1;
   localparam int C_RES_LO = 2;
   localparam int C_LIST = 4;
   localparam int C_DJM = 5;
   localparam int C_CHAN_LO = 6;
   localparam int C_SMP_LO = 10;
   localparam int C_START = 31;
   localparam logic [7:0] OFF0_VALUE = 8'h00;
   // entry sizes as address shifts: 32-bit commands, 16-bit results
   localparam int CMD_SHIFT = 2;
   localparam int RES_SHIFT = 1;
   // phase lengths in converter clock cycles
   localparam logic [4:0] PUMP_CYCLES = 5'h02;
   localparam logic [4:0] BUF_CYCLES = 5'h02;
   localparam logic [4:0] SMP_BASE = 5'h04;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_PUMP = 3'b001,
      PH_SAMPLE = 3'b010,
      PH_HOLD = 3'b011,
      PH_CONV = 3'b100
   } phase_e;
   // resolution codes: 0 = 8 bit, 1 = 10 bit, 2 and 3 = 12 bit
   function automatic logic [3:0] res_bits(input logic [1:0] res);
      unique case (res)
         2'h0: res_bits = 4'h8;
         2'h1: res_bits = 4'hA;
         default: res_bits = 4'hC;
      endcase
   endfunction
endpackage

// ### hdl/sar_if.sv
// sar_if: carrier between the phase sequencer and the bit search engine.
// Assumes both ends run on the same mclk.
`timescale 1ns/100ps
`default_nettype none
interface sar_if;
   logic start;
   logic [1:0] res;
   logic cmp_hi;
   logic [11:0] code;
   logic busy;
   logic done;
   modport seq (output start, output res, output cmp_hi,
      input code, input busy, input done);
   modport core (input start, input res, input cmp_hi,
      output code, output busy, output done);
endinterface
`default_nettype wire

// ### hdl/sar_core.sv
// sar_core: binary search engine, one result bit per mclk.
// Assumes cmp_hi is high when the held sample is above the trial level.
`timescale 1ns/100ps
`default_nettype none
module sar_core (
   input wire logic mclk,
   input wire logic rst_n,
   sar_if.core bus
);
   import sar_pkg::*;

   typedef struct packed {
      logic busy;
      logic done;
      logic [3:0] pos;
      logic [11:0] code;
   } core_s;

   core_s s_r;
   core_s s_nxt;

   // trial bit kept or dropped on the comparator, next bit tried
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (bus.start) begin
         s_nxt.busy = 1'b1;
         s_nxt.pos = res_bits(bus.res) - 4'h1; // RULE_09
         s_nxt.code = '0;
         s_nxt.code[s_nxt.pos] = 1'b1; // RULE_12
      end else if (s_r.busy) begin
         if (!bus.cmp_hi) begin
            s_nxt.code[s_r.pos] = 1'b0; // RULE_10
         end
         if (s_r.pos == 4'h0) begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
         end else begin
            s_nxt.pos = s_r.pos - 4'h1;
            s_nxt.code[s_nxt.pos] = 1'b1; // RULE_12
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.code = s_r.code;
   assign bus.busy = s_r.busy;
   assign bus.done = s_r.done;

   a_eight_bits: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_12
      bus.start && bus.res == 2'h0 |=> bus.busy [*8] ##1 bus.done)
      else $error("8-bit search did not take 8 cycles");
   a_msb_first: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_10
      bus.start && bus.res == 2'h1 |=> bus.code == 12'h200)
      else $error("search did not start at the top bit");
endmodule // sar_core
`default_nettype wire

// ### hdl/sar_adc_sequencer.sv
// sar_adc_sequencer: converter phase control, list offsets and registers.
// Assumes an AXI4-Lite master on mclk and a comparator valid each cycle.
// Function
// RULE_01: list set 0 offset reads zero and ignores every write.
// RULE_02: list set 1 offset writable only when disabled or special access.
// RULE_03: offsets count entries: 16-bit results, 32-bit commands.
// RULE_04: offset applies to command base on fetch, result base on store.
// RULE_05: exactly one input channel is routed to the storage node.
// RULE_06: sample phase starts with two buffered cycles, then direct; here smp 29 gives one buffered and no direct cycle, smp 30 no direct cycle.
// RULE_07: each sample phase follows a two-cycle pump phase.
// RULE_08: hold phase disconnects the input from the storage node.
// RULE_09: resolution selectable as 8, 10 or 12 bits.
// RULE_10: result found by binary search against weighted levels.
// RULE_11: address is base plus active offset plus index.
// RULE_12: one result bit per cycle, top bit first, after sampling.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module sar_adc_sequencer (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [sar_pkg::AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [sar_pkg::DW-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [sar_pkg::AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [sar_pkg::DW-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic cmp_hi,
   output logic pump_en,
   output logic buf_sw,
   output logic dir_sw,
   output logic [15:0] chan_sel,
   output logic [11:0] dac_code,
   output logic fetch_req,
   output logic [sar_pkg::PW-1:0] fetch_addr,
   output logic store_req,
   output logic [sar_pkg::PW-1:0] store_addr,
   output logic [15:0] store_data
);
   import sar_pkg::*;

   typedef struct packed {
      phase_e phase;
      logic [4:0] cnt;
      logic en;
      logic smod;
      logic [1:0] res;
      logic list_sel;
      logic djm;
      logic [3:0] chan;
      logic [4:0] smp;
      logic [PW-1:0] cmd_base;
      logic [PW-1:0] res_base;
      logic [7:0] off1;
      logic [5:0] cmd_idx;
      logic [5:0] res_idx;
      logic [15:0] result;
      logic [PW-1:0] cmd_addr;
      logic [PW-1:0] res_addr;
      logic fetch_req;
      logic store_req;
      logic pump_en;
      logic buf_sw;
      logic dir_sw;
      logic [15:0] chan_oh;
      logic core_start;
      logic aw_got;
      logic w_got;
      logic [AW-1:0] aw_addr;
      logic [DW-1:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [DW-1:0] rdata;
   } seq_s;

   seq_s s_r;
   seq_s s_nxt;
   logic wr_go;
   sar_if sbus ();

   function automatic logic [AW-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = {2'b00, idx, 2'b00};
   endfunction

   // entry counts become byte addresses by the entry size
   function automatic logic [PW-1:0] entry_addr(input logic [PW-1:0] base,
         input logic [7:0] off, input logic [5:0] idx, input int shift);
      logic [PW-1:0] entries;
      entries = PW'({8'h00, off} + {10'h000, idx});
      entry_addr = base + (entries << shift); // RULE_03 RULE_11
   endfunction

   function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
         input logic [DW-1:0] d, input logic [3:0] be);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            merge[8*i +: 8] = d[8*i +: 8];
         end
      end
   endfunction

   function automatic logic [15:0] justify(input logic [11:0] v,
         input logic [1:0] res, input logic djm);
      logic [3:0] n;
      n = res_bits(res);
      if (djm) begin
         justify = {4'h0, v};
      end else begin
         justify = {v, 4'h0} << (4'hC - n);
      end
   endfunction

   assign sbus.start = s_r.core_start;
   assign sbus.res = s_r.res;
   assign sbus.cmp_hi = cmp_hi;

   sar_core u_core (
      .mclk(mclk),
      .rst_n(rst_n),
      .bus(sbus)
   );

   always_comb begin
      logic [DW-1:0] ctrl;
      logic [DW-1:0] nv;
      logic [7:0] widx;
      logic [7:0] ridx;
      logic open;
      logic [7:0] off;
      ctrl = '0;
      nv = '0;
      widx = '0;
      ridx = '0;
      open = 1'b0;
      off = '0;
      s_nxt = s_r;
      s_nxt.fetch_req = 1'b0;
      s_nxt.store_req = 1'b0;
      s_nxt.core_start = 1'b0;
      wr_go = 1'b0;

      // write side: address and data taken in either order
      if (awvalid && s_r.awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_addr = awaddr;
      end
      if (wvalid && s_r.wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = wdata;
         s_nxt.wstrb = wstrb;
      end
      if (s_r.bvalid && bready) begin
         s_nxt.bvalid = 1'b0;
      end
      ctrl[C_EN] = s_r.en;
      ctrl[C_SMOD] = s_r.smod;
      ctrl[C_RES_LO +: 2] = s_r.res;
      ctrl[C_LIST] = s_r.list_sel;
      ctrl[C_DJM] = s_r.djm;
      ctrl[C_CHAN_LO +: 4] = s_r.chan;
      ctrl[C_SMP_LO +: 5] = s_r.smp;
      // address registers only move while stopped or in special access
      open = !s_r.en || s_r.smod; // RULE_02
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
         wr_go = 1'b1;
         widx = s_r.aw_addr[9:2];
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = RESP_OKAY;
         if (s_r.aw_addr[AW-1:10] != '0) begin
            s_nxt.bresp = RESP_SLVERR;
         end else if (widx == IDX_CTRL) begin
            nv = merge(ctrl, s_r.wdata, s_r.wstrb);
            s_nxt.en = nv[C_EN];
            s_nxt.smod = nv[C_SMOD];
            s_nxt.res = nv[C_RES_LO +: 2];
            s_nxt.list_sel = nv[C_LIST];
            s_nxt.djm = nv[C_DJM];
            s_nxt.chan = nv[C_CHAN_LO +: 4];
            s_nxt.smp = nv[C_SMP_LO +: 5];
            // start is a write-one pulse, honoured only when idle
            if (nv[C_START] && nv[C_EN] && s_r.phase == PH_IDLE) begin
               // list select of this same write governs the fetch
               off = nv[C_LIST] ? s_r.off1 : OFF0_VALUE;
               s_nxt.cmd_addr = entry_addr(s_r.cmd_base, off, // RULE_04
                  s_r.cmd_idx, CMD_SHIFT);
               s_nxt.fetch_req = 1'b1;
               s_nxt.phase = PH_PUMP;
               s_nxt.cnt = '0;
            end
         end else if (widx == IDX_CMD_BASE) begin
            if (open) begin
               nv = merge({8'h00, s_r.cmd_base}, s_r.wdata, s_r.wstrb);
               s_nxt.cmd_base = nv[PW-1:0];
            end
         end else if (widx == IDX_RES_BASE) begin
            if (open) begin
               nv = merge({8'h00, s_r.res_base}, s_r.wdata, s_r.wstrb);
               s_nxt.res_base = nv[PW-1:0];
            end
         end else if (widx == IDX_OFF1) begin
            if (open && s_r.wstrb[0]) begin
               s_nxt.off1 = s_r.wdata[7:0]; // RULE_02
            end
         end else if (widx == IDX_OFF0 || widx == IDX_STATUS ||
               widx == IDX_RESULT || widx == IDX_INDEX) begin
            s_nxt.bresp = RESP_OKAY; // read-only, write dropped RULE_01
         end else begin
            s_nxt.bresp = RESP_SLVERR;
         end
      end
      s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
      s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;

      // read side: one read at a time, data one cycle after the address
      if (s_r.rvalid && rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (arvalid && s_r.arready) begin
         ridx = araddr[9:2];
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = RESP_OKAY;
         s_nxt.rdata = '0;
         if (araddr[AW-1:10] != '0) begin
            s_nxt.rresp = RESP_SLVERR;
         end else if (ridx == IDX_CTRL) begin
            s_nxt.rdata = ctrl;
         end else if (ridx == IDX_STATUS) begin
            s_nxt.rdata = {24'h000000, 2'b00, sbus.busy,
               s_r.phase == PH_IDLE, 1'b0, s_r.phase};
         end else if (ridx == IDX_CMD_BASE) begin
            s_nxt.rdata = {8'h00, s_r.cmd_base};
         end else if (ridx == IDX_RES_BASE) begin
            s_nxt.rdata = {8'h00, s_r.res_base};
         end else if (ridx == IDX_RESULT) begin
            s_nxt.rdata = {16'h0000, s_r.result};
         end else if (ridx == IDX_INDEX) begin
            s_nxt.rdata = {18'h00000, s_r.res_idx, 2'b00, s_r.cmd_idx};
         end else if (ridx == IDX_OFF0) begin
            s_nxt.rdata = {24'h000000, OFF0_VALUE}; // RULE_01
         end else if (ridx == IDX_OFF1) begin
            s_nxt.rdata = {24'h000000, s_r.off1};
         end else begin
            s_nxt.rresp = RESP_SLVERR;
         end
      end
      s_nxt.arready = !s_nxt.rvalid;

      // conversion phases; dropping enable aborts back to idle
      s_nxt.pump_en = 1'b0;
      s_nxt.buf_sw = 1'b0;
      s_nxt.dir_sw = 1'b0;
      unique case (s_r.phase)
         PH_IDLE: begin
            // pump output rises with the phase so it spans both cycles
            s_nxt.pump_en = s_nxt.phase == PH_PUMP; // RULE_07
         end
         PH_PUMP: begin
            s_nxt.cnt = s_r.cnt + 5'h01;
            s_nxt.pump_en = 1'b1; // RULE_07
            if (s_r.cnt == PUMP_CYCLES - 5'h01) begin
               s_nxt.pump_en = 1'b0;
               s_nxt.buf_sw = 1'b1; // RULE_06
               s_nxt.phase = PH_SAMPLE;
               s_nxt.cnt = '0;
            end
         end
         PH_SAMPLE: begin
            s_nxt.cnt = s_r.cnt + 5'h01;
            // buffer first to spare the source, then the direct path
            s_nxt.buf_sw = s_nxt.cnt < BUF_CYCLES; // RULE_06
            s_nxt.dir_sw = !s_nxt.buf_sw;
            if (s_r.cnt == s_r.smp + SMP_BASE - 5'h01) begin
               s_nxt.buf_sw = 1'b0; // RULE_08
               s_nxt.dir_sw = 1'b0;
               s_nxt.core_start = 1'b1; // RULE_12
               s_nxt.phase = PH_HOLD;
            end
         end
         PH_HOLD: begin
            s_nxt.phase = PH_CONV;
         end
         PH_CONV: begin
            if (sbus.done) begin
               off = s_r.list_sel ? s_r.off1 : OFF0_VALUE;
               s_nxt.result = justify(sbus.code, s_r.res, s_r.djm);
               s_nxt.res_addr = entry_addr(s_r.res_base, off, // RULE_04
                  s_r.res_idx, RES_SHIFT);
               s_nxt.store_req = 1'b1;
               s_nxt.cmd_idx = s_r.cmd_idx + 6'h01;
               s_nxt.res_idx = s_r.res_idx + 6'h01;
               s_nxt.phase = PH_IDLE;
            end
         end
         default: begin
            s_nxt.phase = PH_IDLE;
         end
      endcase
      if (!s_nxt.en) begin
         s_nxt.phase = PH_IDLE;
         s_nxt.pump_en = 1'b0;
         s_nxt.buf_sw = 1'b0;
         s_nxt.dir_sw = 1'b0;
         s_nxt.cmd_idx = '0;
         s_nxt.res_idx = '0;
      end
      s_nxt.chan_oh = 16'h0001 << s_nxt.chan; // RULE_05
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.chan_oh <= 16'h0001;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from the state flops
   assign awready = s_r.awready;
   assign wready = s_r.wready;
   assign bresp = s_r.bresp;
   assign bvalid = s_r.bvalid;
   assign arready = s_r.arready;
   assign rdata = s_r.rdata;
   assign rresp = s_r.rresp;
   assign rvalid = s_r.rvalid;
   assign pump_en = s_r.pump_en;
   assign buf_sw = s_r.buf_sw;
   assign dir_sw = s_r.dir_sw;
   assign chan_sel = s_r.chan_oh;
   assign dac_code = sbus.code;
   assign fetch_req = s_r.fetch_req;
   assign fetch_addr = s_r.cmd_addr;
   assign store_req = s_r.store_req;
   assign store_addr = s_r.res_addr;
   assign store_data = s_r.result;

   a_off0_zero: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_01
      arvalid && arready && araddr == reg_addr(IDX_OFF0) |=> rdata == '0)
      else $error("list set 0 offset read not zero");
   a_off1_locked: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_02
      wr_go && s_r.en && !s_r.smod |=> $stable(s_r.off1))
      else $error("list set 1 offset changed while locked");
   a_pump_two: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_07
      $rose(pump_en) |-> pump_en [*2] ##1 (buf_sw && !pump_en))
      else $error("pump phase not two cycles");
   a_buffer_two: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_06
      $rose(buf_sw) |-> buf_sw [*2] ##1 (dir_sw && !buf_sw))
      else $error("buffered sampling not two cycles");
   a_hold_open: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_08
      s_r.phase == PH_HOLD || s_r.phase == PH_CONV |-> !buf_sw && !dir_sw)
      else $error("input connected during hold");
   a_one_chan: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_05
      $onehot(chan_sel))
      else $error("channel select not one-hot");
   a_fetch_addr: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_11
      fetch_req && !s_r.list_sel |-> fetch_addr ==
         s_r.cmd_base + {16'h0000, s_r.cmd_idx, 2'b00})
      else $error("list 0 fetch address wrong");
   a_conv_bound: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_09
      $rose(s_r.core_start) && s_r.res == 2'h0 |-> ##10 store_req)
      else $error("8-bit conversion not stored on time");
endmodule // sar_adc_sequencer
`default_nettype wire

// ### sim/sar_analog_model.sv
// sar_analog_model: far-side stand-in for the storage node and comparator.
// Assumes the bench gives the input level as a code in the active resolution.
`timescale 1ns/100ps
`default_nettype none
module sar_analog_model (
   input wire logic mclk,
   input wire logic buf_sw,
   input wire logic dir_sw,
   input wire logic [11:0] vin,
   input wire logic [11:0] dac_code,
   output logic cmp_hi
);
   logic [11:0] held_r = 12'h000;

   // node tracks the input only while a switch is closed, else it holds
   always_ff @(posedge mclk) begin
      if (buf_sw || dir_sw) begin
         held_r <= vin;
      end
   end

   // level sits mid-bin, so an equal trial code reads as below the sample
   always_comb begin
      cmp_hi = ({held_r, 1'b1} > {dac_code, 1'b0});
   end
endmodule // sar_analog_model
`default_nettype wire

// ### sim/tb_top.sv
// tb_top: self-checking bench for the converter sequencer.
// Assumes sar_pkg, the design and the analog model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import sar_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic [11:0] vin = 12'h000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, cmp_hi, pump_en;
   logic buf_sw, dir_sw, fetch_req, store_req, store_seen;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] chan_sel, store_data;
   logic [11:0] dac_code;
   logic [23:0] fetch_addr, store_addr;
   int fails = 0;
   int samples_checked = 0;
   int n_pump, n_buf, n_dir, n_conv, n_fetch;

   always #5 mclk = ~mclk;

   sar_adc_sequencer i_dut (.mclk(mclk), .rst_n(rst_n),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .cmp_hi(cmp_hi), .pump_en(pump_en), .buf_sw(buf_sw),
      .dir_sw(dir_sw), .chan_sel(chan_sel), .dac_code(dac_code),
      .fetch_req(fetch_req), .fetch_addr(fetch_addr),
      .store_req(store_req), .store_addr(store_addr),
      .store_data(store_data));

   sar_analog_model i_ana (.mclk(mclk), .buf_sw(buf_sw), .dir_sw(dir_sw),
      .vin(vin), .dac_code(dac_code), .cmp_hi(cmp_hi));

   task automatic stop_test();
      if (fails == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask

   // a hung handshake counts against the run and ends it
   task automatic timeout();
      fails++;
      stop_test();
   endtask

   function automatic logic [11:0] ad(input logic [7:0] idx);
      ad = {2'b00, idx, 2'b00};
   endfunction

   // control word: en set, special access clear, start clear
   function automatic logic [31:0] cw(input logic [1:0] res,
      input logic list, input logic djm, input logic [3:0] ch,
      input logic [4:0] smp);
      cw = {17'h0, smp, ch, djm, list, res, 2'b01};
   endfunction

   // write: address and data offered together, each held until taken
   task automatic bus_wr(input logic [11:0] a, input logic [31:0] d,
      output logic [1:0] r);
      int k;
      k = 0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge mclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
         k++;
         if (k > 200) timeout();
      end
   endtask

   // read: address held until taken, data taken on the rvalid edge
   task automatic bus_rd(input logic [11:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int k;
      k = 0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge mclk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
         k++;
         if (k > 200) timeout();
      end
   endtask

   // phase tally; order faults are flagged in the cycle they show
   always @(posedge mclk) begin
      if (pump_en === 1'b1) n_pump++;
      if (fetch_req === 1'b1) n_fetch++;
      if (buf_sw === 1'b1) begin
         n_buf++;
         chk("pump_before_sample", 32'd2, n_pump);
      end
      if (dir_sw === 1'b1) begin
         n_dir++;
         chk("buffered_before_direct", 32'd2, n_buf);
      end
      if ((buf_sw | dir_sw) === 1'b1 && n_conv > 0) begin
         chk("switch_open_in_hold", 32'd0, 32'd1);
      end
      if (n_dir > 0 && store_seen !== 1'b1 && pump_en === 1'b0 &&
         buf_sw === 1'b0 && dir_sw === 1'b0) n_conv++;
      if (store_req === 1'b1) store_seen = 1'b1;
   end

   // reset state and an unmapped place
   task automatic reg_checks();
      logic [31:0] d;
      logic [1:0] r;
      chk("chan_sel_reset", 32'h1, {16'h0, chan_sel});
      bus_rd(12'h0C0, d, r);
      chk("unmapped_rd_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      chk("unmapped_rd_data", 32'h0, d);
      bus_wr(12'h0C0, 32'h1, r);
      chk("unmapped_wr_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
   endtask

   // list offset write rules under each enable setting
   task automatic offset_access();
      logic [31:0] d;
      logic [1:0] r;
      bus_wr(ad(IDX_OFF0), 32'hFF, r);
      chk("off0_wr_resp", {30'h0, RESP_OKAY}, {30'h0, r});
      bus_rd(ad(IDX_OFF0), d, r);
      chk("off0_value", 32'h0, d);
      bus_wr(ad(IDX_OFF1), 32'hFFFF_FF13, r);
      bus_rd(ad(IDX_OFF1), d, r);
      chk("off1_open", 32'h13, {24'h0, d[7:0]});
      // low lane strobe off: the offset byte must not move
      wstrb <= 4'hE;
      bus_wr(ad(IDX_OFF1), 32'h77, r);
      wstrb <= 4'hF;
      bus_rd(ad(IDX_OFF1), d, r);
      chk("off1_lane_off", 32'h13, {24'h0, d[7:0]});
      bus_wr(ad(IDX_CTRL), 32'h1, r);
      bus_wr(ad(IDX_OFF1), 32'h55, r);
      bus_rd(ad(IDX_OFF1), d, r);
      chk("off1_locked", 32'h13, {24'h0, d[7:0]});
      bus_wr(ad(IDX_CTRL), 32'h3, r);
      bus_wr(ad(IDX_OFF1), 32'h21, r);
      bus_rd(ad(IDX_OFF1), d, r);
      chk("off1_special", 32'h21, {24'h0, d[7:0]});
   endtask

   // one conversion per resolution code, both lists and justifications
   task automatic conversions();
      logic [1:0] rs [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
      logic ls [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
      logic ds [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
      logic [4:0] sm [4] = '{5'h00, 5'h03, 5'h14, 5'h01};
      logic [11:0] vn [4] = '{12'h0A5, 12'h2B7, 12'hABC, 12'h001};
      logic [31:0] d, c;
      logic [1:0] r;
      logic [7:0] off;
      int n, k;
      bus_wr(ad(IDX_CTRL), 32'h0, r);
      bus_wr(ad(IDX_CMD_BASE), 32'h0000_1000, r);
      bus_wr(ad(IDX_RES_BASE), 32'h0000_2000, r);
      for (int i = 0; i < 4; i++) begin
         n = (rs[i] == 2'h0) ? 8 : (rs[i] == 2'h1) ? 10 : 12;
         off = ls[i] ? 8'h21 : 8'h00;
         c = cw(rs[i], ls[i], ds[i], 4'(i * 5), sm[i]);
         bus_wr(ad(IDX_CTRL), c, r);
         n_pump = 0;
         n_buf = 0;
         n_dir = 0;
         n_conv = 0;
         n_fetch = 0;
         store_seen = 1'b0;
         vin <= vn[i];
         bus_wr(ad(IDX_CTRL), c | 32'h8000_0000, r);
         k = 0;
         while (store_seen !== 1'b1) begin
            @(posedge mclk);
            k++;
            if (k > 300) timeout();
         end
         chk("fetch_addr", 32'(24'h1000 + ((32'(off) + i) << 2)),
            {8'h0, fetch_addr});
         chk("fetch_pulses", 32'd1, n_fetch);
         chk("store_addr", 32'(24'h2000 + ((32'(off) + i) << 1)),
            {8'h0, store_addr});
         chk("pump_cycles", 32'd2, n_pump);
         chk("buffered_cycles", 32'd2, n_buf);
         chk("direct_cycles", 32'(sm[i]) + 32'd2, n_dir);
         chk("search_cycles", 32'(n + 3), n_conv);
         chk("store_data", ds[i] ? {20'h0, vn[i]} :
            32'(16'({4'h0, vn[i]} << (16 - n))), {16'h0, store_data});
         chk("chan_sel", 32'h1 << (i * 5), {16'h0, chan_sel});
         bus_rd(ad(IDX_INDEX), d, r);
         chk("list_index", 32'(((i + 1) << 8) | (i + 1)), d);
      end
   endtask

   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      reg_checks();
      offset_access();
      conversions();
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
